//--- rtl/boot_seq_pkg.sv
// constants, codes and state type for the boot voltage sequencer
package boot_seq_pkg;
   localparam int VID_W = 11;                      // voltage code in millivolts
   localparam logic [VID_W-1:0] BOOT_MV_00 = 11'h44C;   // 1.1 V
   localparam logic [VID_W-1:0] BOOT_MV_01 = 11'h3E8;   // 1.0 V
   localparam logic [VID_W-1:0] BOOT_MV_10 = 11'h384;   // 0.9 V
   localparam logic [VID_W-1:0] BOOT_MV_11 = 11'h320;   // 0.8 V
   localparam logic [VID_W-1:0] VID_ZERO   = 11'h000;
   localparam logic [VID_W-1:0] VID_STEP   = 11'h001;   // one millivolt per slew step
   localparam int CLK_MHZ      = 20;
   localparam int PG_EXTRA_US  = 20;
   localparam int PG_EXTRA_CYC = PG_EXTRA_US * CLK_MHZ;
   localparam int HOLD_W       = 9;
   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(PG_EXTRA_CYC - 1);
   localparam logic [HOLD_W-1:0] HOLD_ZERO = 9'h000;
   localparam logic [HOLD_W-1:0] HOLD_ONE  = 9'h001;
   localparam int SLEW_DIV_W = 16;
   localparam logic [SLEW_DIV_W-1:0] DIV_ZERO = 16'h0000;
   localparam logic [SLEW_DIV_W-1:0] DIV_ONE  = 16'h0001;

   typedef enum logic [6:0] {
      ST_IDLE      = 7'h01,
      ST_BOOT_RAMP = 7'h02,
      ST_BOOT_HOLD = 7'h04,
      ST_BOOT_DONE = 7'h08,
      ST_SVI_RUN   = 7'h10,
      ST_REC_RAMP  = 7'h20,
      ST_REC_HOLD  = 7'h40
   } seq_state_type;

   function automatic logic [VID_W-1:0] boot_decode(input logic clk, input logic dat);
      case ({clk, dat})
         2'h0:    boot_decode = BOOT_MV_00;
         2'h1:    boot_decode = BOOT_MV_01;
         2'h2:    boot_decode = BOOT_MV_10;
         default: boot_decode = BOOT_MV_11;
      endcase
   endfunction
endpackage

//--- rtl/ramp_if.sv
// link between the sequencer and its slew ramp
`timescale 1ns/1ns
`default_nettype none
interface ramp_if;
   logic [boot_seq_pkg::VID_W-1:0]      target;
   logic                                clear;
   logic [boot_seq_pkg::SLEW_DIV_W-1:0] divisor;
   logic [boot_seq_pkg::VID_W-1:0]      level;
   logic                                atTarget;
   modport ctl  (output target, output clear, output divisor, input level, input atTarget);
   modport ramp (input target, input clear, input divisor, output level, output atTarget);
endinterface
`default_nettype wire

//--- rtl/vid_slew_ramp.sv
// slew-limited voltage code ramp with step divider
`timescale 1ns/1ns
`default_nettype none
module vid_slew_ramp (
   input  wire logic ref_clk,
   input  wire logic nrst,
   ramp_if.ramp      rp
);
   typedef struct packed {
      logic [boot_seq_pkg::VID_W-1:0]      level;
      logic [boot_seq_pkg::SLEW_DIV_W-1:0] divCnt;
   } ramp_state_type;

   ramp_state_type s_r;
   ramp_state_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (rp.clear) begin
         // discharged output: restart soft-start from zero
         s_nxt.level  = boot_seq_pkg::VID_ZERO;
         s_nxt.divCnt = boot_seq_pkg::DIV_ZERO;
      end else if (s_r.level == rp.target) begin
         s_nxt.divCnt = boot_seq_pkg::DIV_ZERO;
      end else if (s_r.divCnt >= rp.divisor) begin
         s_nxt.divCnt = boot_seq_pkg::DIV_ZERO;
         if (s_r.level < rp.target) begin
            s_nxt.level = s_r.level + boot_seq_pkg::VID_STEP;
         end else begin
            s_nxt.level = s_r.level - boot_seq_pkg::VID_STEP;
         end
      end else begin
         s_nxt.divCnt = s_r.divCnt + boot_seq_pkg::DIV_ONE;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rp.level    = s_r.level;
   assign rp.atTarget = (s_r.level == rp.target);
endmodule // vid_slew_ramp
`default_nettype wire

//--- rtl/boot_voltage_sequencer.sv
// boot voltage sequencing, stored boot code and power-good control
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - after shutdown release, two serial lines decode to 1.1/1.0/0.9/0.8 V
// - boot target follows the lines after shutdown release until power-good rises
// - power-ok rises after boot voltage; serial commands then replace boot lines
// - boot code is stored at the first power-good assertion after startup
// - rising shutdown control clears the stored boot code
// - power-ok falling after its first rise returns target to stored code
// - power-good low during that return until code matches, plus 20 us
// - code slews toward the target at the configured rate; shutdown clears it to zero at once
// - later power-ok rising edges leave the stored code unchanged
// - power-good comes from regulation state; a power-ok drop only clears it by starting the return to stored code
// - second ground sense above 0.9 V selects combined mode using the first
// - discharge switch on the second sense pin is on while shut down
// - at startup power-good stays low 20 us after reaching boot voltage
// - power-good is held low throughout shutdown
module boot_voltage_sequencer (
   input  wire logic                                ref_clk,
   input  wire logic                                nrst,
   input  wire logic                                shutdown_control,
   input  wire logic                                serial_vid_clock_line,
   input  wire logic                                serial_vid_data_line,
   input  wire logic                                system_power_ok_in,
   input  wire logic                                sviCmdValid,
   input  wire logic [boot_seq_pkg::VID_W-1:0]      sviCmdCode,
   input  wire logic [boot_seq_pkg::SLEW_DIV_W-1:0] slewDivisor,
   input  wire logic                                groundSenseBAboveThr,
   output var  logic                                power_good_out,
   output var  logic                                powerGoodOeN,
   output var  logic [boot_seq_pkg::VID_W-1:0]      vidCode,
   output var  logic                                combinedCoreMode,
   output var  logic                                dischargeSwitchB,
   output var  logic                                sviActive
);
   typedef struct packed {
      boot_seq_pkg::seq_state_type         state;
      logic [boot_seq_pkg::VID_W-1:0]      target;
      logic [boot_seq_pkg::VID_W-1:0]      storedCode;
      logic                                storedValid;
      logic                                pokSeen;
      logic                                pokPrev;
      logic                                shdnPrev;
      logic [boot_seq_pkg::HOLD_W-1:0]     holdCnt;
      logic                                pg;
      logic                                combined;
      logic                                discharge;
      logic                                svi;
   } seq_reg_type;

   seq_reg_type s_r;
   seq_reg_type s_nxt;
   ramp_if      rif ();

   logic [boot_seq_pkg::VID_W-1:0] bootDecoded;
   logic                           pokRise;
   logic                           pokFall;

   assign bootDecoded = boot_seq_pkg::boot_decode(serial_vid_clock_line, serial_vid_data_line);
   assign pokRise     = system_power_ok_in && !s_r.pokPrev;
   assign pokFall     = !system_power_ok_in && s_r.pokPrev;

   always_comb begin
      s_nxt           = s_r;
      s_nxt.shdnPrev  = shutdown_control;
      s_nxt.pokPrev   = system_power_ok_in;
      s_nxt.combined  = groundSenseBAboveThr;
      s_nxt.discharge = !shutdown_control;
      if (shutdown_control && !s_r.shdnPrev) begin
         s_nxt.storedValid = 1'b0;
      end
      if (!shutdown_control) begin
         // inputs ignored; power-good pulled low for the whole shutdown
         s_nxt.state   = boot_seq_pkg::ST_IDLE;
         s_nxt.pg      = 1'b0;
         s_nxt.pokSeen = 1'b0;
         s_nxt.holdCnt = boot_seq_pkg::HOLD_ZERO;
         s_nxt.target  = boot_seq_pkg::VID_ZERO;
      end else begin
         case (s_r.state)
            boot_seq_pkg::ST_IDLE: begin
               s_nxt.target = bootDecoded;
               s_nxt.state  = boot_seq_pkg::ST_BOOT_RAMP;
            end
            boot_seq_pkg::ST_BOOT_RAMP: begin
               s_nxt.target = bootDecoded;
               if (rif.atTarget && rif.level == bootDecoded) begin
                  s_nxt.state   = boot_seq_pkg::ST_BOOT_HOLD;
                  s_nxt.holdCnt = boot_seq_pkg::HOLD_ZERO;
               end
            end
            boot_seq_pkg::ST_BOOT_HOLD: begin
               s_nxt.target = bootDecoded;
               if (bootDecoded != s_r.target) begin
                  s_nxt.state = boot_seq_pkg::ST_BOOT_RAMP;
               end else if (s_r.holdCnt == boot_seq_pkg::HOLD_LAST) begin
                  s_nxt.state = boot_seq_pkg::ST_BOOT_DONE;
                  s_nxt.pg    = 1'b1;
                  if (!s_r.storedValid) begin
                     s_nxt.storedCode  = s_r.target;
                     s_nxt.storedValid = 1'b1;
                  end
               end else begin
                  s_nxt.holdCnt = s_r.holdCnt + boot_seq_pkg::HOLD_ONE;
               end
            end
            boot_seq_pkg::ST_BOOT_DONE: begin
               // stored code is not touched here on later rises
               if (pokRise) begin
                  s_nxt.state   = boot_seq_pkg::ST_SVI_RUN;
                  s_nxt.pokSeen = 1'b1;
               end else if (s_r.pokSeen && pokFall) begin
                  s_nxt.state  = boot_seq_pkg::ST_REC_RAMP;
                  s_nxt.target = s_r.storedCode;
                  s_nxt.pg     = 1'b0;
               end
            end
            boot_seq_pkg::ST_SVI_RUN: begin
               if (!system_power_ok_in) begin
                  s_nxt.state  = boot_seq_pkg::ST_REC_RAMP;
                  s_nxt.target = s_r.storedCode;
                  s_nxt.pg     = 1'b0;
               end else if (sviCmdValid) begin
                  s_nxt.target = sviCmdCode;
               end
            end
            boot_seq_pkg::ST_REC_RAMP: begin
               s_nxt.pg = 1'b0;
               if (rif.atTarget) begin
                  s_nxt.state   = boot_seq_pkg::ST_REC_HOLD;
                  s_nxt.holdCnt = boot_seq_pkg::HOLD_ZERO;
               end
            end
            boot_seq_pkg::ST_REC_HOLD: begin
               if (s_r.holdCnt == boot_seq_pkg::HOLD_LAST) begin
                  // power-ok rising again is taken only once recovery ends
                  s_nxt.state = boot_seq_pkg::ST_BOOT_DONE;
                  s_nxt.pg    = 1'b1;
               end else begin
                  s_nxt.holdCnt = s_r.holdCnt + boot_seq_pkg::HOLD_ONE;
               end
            end
            default: begin
               s_nxt.state = boot_seq_pkg::ST_IDLE;
               s_nxt.pg    = 1'b0;
            end
         endcase
      end
      // registered decode keeps the status pin glitch-free
      s_nxt.svi = (s_nxt.state == boot_seq_pkg::ST_SVI_RUN);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_r       <= '0;
         s_r.state <= boot_seq_pkg::ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rif.target  = s_r.target;
   assign rif.clear   = s_r.discharge;
   assign rif.divisor = slewDivisor;

   vid_slew_ramp u_ramp (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .rp      (rif.ramp)
   );

   // open-drain power-good: pin data always low, enable low while pulling
   assign power_good_out   = 1'b0;
   assign powerGoodOeN     = s_r.pg;
   assign vidCode          = rif.level;
   assign combinedCoreMode = s_r.combined;
   assign dischargeSwitchB = s_r.discharge;
   assign sviActive        = s_r.svi;

   // checks
   localparam int HOLD_CYC = boot_seq_pkg::PG_EXTRA_CYC;
   logic [boot_seq_pkg::HOLD_W:0] lowAtTgt;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         lowAtTgt <= '0;
      end else if (s_r.pg || !rif.atTarget || !shutdown_control) begin
         lowAtTgt <= '0;
      end else if (lowAtTgt < (boot_seq_pkg::HOLD_W+1)'(HOLD_CYC + 1)) begin
         lowAtTgt <= lowAtTgt + 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_svi_drop;
      s_r.state == boot_seq_pkg::ST_SVI_RUN && !system_power_ok_in && shutdown_control;
   endsequence
   sequence s_rec_low;
      (!s_r.pg)[*8];
   endsequence

   property p_boot_decode;
      (s_r.state == boot_seq_pkg::ST_BOOT_RAMP && shutdown_control)
         |=> s_r.target == $past(bootDecoded);
   endproperty
   a_boot_decode: assert property (p_boot_decode) else $error("boot target mismatch");
   property p_svi_cmd;
      (s_r.state == boot_seq_pkg::ST_SVI_RUN && system_power_ok_in && sviCmdValid
       && shutdown_control) |=> s_r.target == $past(sviCmdCode);
   endproperty
   a_svi_cmd: assert property (p_svi_cmd) else $error("command not applied");
   property p_store;
      $rose(s_r.storedValid) |-> s_r.pg && s_r.storedCode == $past(s_r.target);
   endproperty
   a_store: assert property (p_store) else $error("boot code not stored");
   property p_clear;
      (shutdown_control && !s_r.shdnPrev) |=> !s_r.storedValid;
   endproperty
   a_clear: assert property (p_clear) else $error("stored code not cleared");
   property p_recover;
      s_svi_drop |=> s_r.target == $past(s_r.storedCode) ##0 s_rec_low;
   endproperty
   a_recover: assert property (p_recover) else $error("no return to boot code");
   property p_pg_delay;
      $rose(s_r.pg) |-> $past(lowAtTgt) >= HOLD_CYC - 1;
   endproperty
   a_pg_delay: assert property (p_pg_delay) else $error("power-good too early");
   property p_slew;
      // the clear that zeroes the code acts one edge after discharge is seen
      $changed(rif.level) && !$past(s_r.discharge) |->
         (rif.level == $past(rif.level) + boot_seq_pkg::VID_STEP)
         || (rif.level == $past(rif.level) - boot_seq_pkg::VID_STEP);
   endproperty
   a_slew: assert property (p_slew) else $error("code jumped");
   property p_keep_stored;
      (s_r.storedValid && shutdown_control) |=> $stable(s_r.storedCode);
   endproperty
   a_keep_stored: assert property (p_keep_stored) else $error("stored code changed");
   property p_combined;
      groundSenseBAboveThr |=> combinedCoreMode;
   endproperty
   a_combined: assert property (p_combined) else $error("combined mode missed");
   property p_discharge;
      !shutdown_control |=> dischargeSwitchB && !s_r.pg && s_r.state == boot_seq_pkg::ST_IDLE;
   endproperty
   a_discharge: assert property (p_discharge) else $error("shutdown not honoured");
endmodule // boot_voltage_sequencer
`default_nettype wire

//--- sim/sys_power_mgr.sv
// system power management model: boot select lines, power-ok and serial commands
`timescale 1ns/1ns
`default_nettype none
module sys_power_mgr (
   input  wire logic                           ref_clk,
   input  wire logic                           nrst,
   input  wire logic                           powerGood,
   input  wire logic [1:0]                     bootSel,
   input  wire logic                           wantPok,
   input  wire logic                           cmdReq,
   input  wire logic [boot_seq_pkg::VID_W-1:0] newCode,
   output var  logic                           clockLine,
   output var  logic                           dataLine,
   output var  logic                           powerOk,
   output var  logic                           cmdValid,
   output var  logic [boot_seq_pkg::VID_W-1:0] cmdCode
);
   logic cmdReqD;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         clockLine <= 1'b0;
         dataLine  <= 1'b0;
         powerOk   <= 1'b0;
         cmdValid  <= 1'b0;
         cmdReqD   <= 1'b0;
         cmdCode   <= 11'h000;
      end else begin
         clockLine <= bootSel[1];
         dataLine  <= bootSel[0];
         // power-ok only rises once the device reports power good
         powerOk   <= wantPok & (powerOk | powerGood);
         cmdReqD   <= cmdReq;
         cmdValid  <= cmdReq & ~cmdReqD;
         // code is meaningless outside the pulse, so it keeps moving
         cmdCode   <= (cmdReq & ~cmdReqD) ? newCode : ~cmdCode;
      end
   end
endmodule // sys_power_mgr
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the boot voltage sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        ref_clk, nrst, shutdownCtl, groundB, wantPok, cmdReq;
   logic [1:0]  bootSel;
   logic [10:0] newCode, vidCode, cmdCode;
   logic [15:0] slewDiv;
   logic        clkLine, datLine, pok, cmdValid;
   logic        pgPin, pgOeN, combined, discharge, sviActive;
   int          failures = 0;
   int          compares = 0;
   int          cycles = 0;

   sys_power_mgr partner (.ref_clk(ref_clk), .nrst(nrst), .powerGood(pgOeN),
      .bootSel(bootSel), .wantPok(wantPok), .cmdReq(cmdReq), .newCode(newCode),
      .clockLine(clkLine), .dataLine(datLine), .powerOk(pok), .cmdValid(cmdValid),
      .cmdCode(cmdCode));
   boot_voltage_sequencer dut (.ref_clk(ref_clk), .nrst(nrst),
      .shutdown_control(shutdownCtl), .serial_vid_clock_line(clkLine),
      .serial_vid_data_line(datLine), .system_power_ok_in(pok),
      .sviCmdValid(cmdValid), .sviCmdCode(cmdCode), .slewDivisor(slewDiv),
      .groundSenseBAboveThr(groundB), .power_good_out(pgPin), .powerGoodOeN(pgOeN),
      .vidCode(vidCode), .combinedCoreMode(combined), .dischargeSwitchB(discharge),
      .sviActive(sviActive));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ceiling well above the longest expected run
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         complete_run();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
         failures++;
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask

   // wait for power good, watching slew steps and the post-target hold
   task automatic settle(input logic [10:0] exp);
      int n, hold, jumps;
      logic [10:0] prev;
      n = 0;
      hold = 0;
      jumps = 0;
      prev = vidCode;
      while (pgOeN !== 1'b1 && n < 5000) begin
         step(1);
         n++;
         if (vidCode === exp) hold++;
         if (vidCode - prev > 11'h001 && prev - vidCode > 11'h001) jumps++;
         prev = vidCode;
      end
      check("powerGood", 16'(pgOeN), 16'h0001);
      check("vidCode", 16'(vidCode), 16'(exp));
      check("slewJumps", 16'(jumps), 16'h0000);
      check("pgHold", 16'(hold >= 400 && hold <= 403), 16'h0001);
   endtask

   task automatic boot(input logic [1:0] sel, input logic [10:0] exp);
      shutdownCtl = 1'b0;
      wantPok = 1'b0;
      bootSel = ~sel;
      step(3);
      bootSel = sel;
      step(2);
      check("pgInShutdown", 16'(pgOeN), 16'h0000);
      check("discharge", 16'(discharge), 16'h0001);
      check("sviInShutdown", 16'(sviActive), 16'h0000);
      check("vidInShutdown", 16'(vidCode), 16'h0000);
      check("pgPin", 16'(pgPin), 16'h0000);
      shutdownCtl = 1'b1;
      step(2);
      check("dischargeOff", 16'(discharge), 16'h0000);
      settle(exp);
   endtask

   // boot lines move early in the ramp; target follows them
   task automatic follow_lines();
      shutdownCtl = 1'b0;
      bootSel = 2'h0;
      step(3);
      shutdownCtl = 1'b1;
      step(50);
      bootSel = 2'h3;
      settle(boot_seq_pkg::BOOT_MV_11);
   endtask

   // serial command at slewDivisor 1, then power-ok drop back to stored code
   task automatic svi_and_return(input logic [10:0] cmd, input logic [10:0] stored);
      int n, span;
      wantPok = 1'b1;
      step(4);
      check("sviActive", 16'(sviActive), 16'h0001);
      bootSel = ~bootSel;
      newCode = cmd;
      cmdReq = 1'b1;
      step(1);
      cmdReq = 1'b0;
      n = 0;
      while (vidCode !== cmd && n < 3000) begin
         step(1);
         n++;
      end
      span = (cmd > stored) ? 2 * (cmd - stored) : 2 * (stored - cmd);
      check("cmdReached", 16'(vidCode), 16'(cmd));
      check("slewRate", 16'(n >= span - 2 && n <= span + 4), 16'h0001);
      step(450);
      wantPok = 1'b0;
      step(3);
      check("pgRecovery", 16'(pgOeN), 16'h0000);
      settle(stored);
      check("pgWithoutPok", 16'({pok, pgOeN}), 16'h0001);
   endtask

   initial begin
      nrst = 1'b0;
      shutdownCtl = 1'b0;
      groundB = 1'b0;
      wantPok = 1'b0;
      cmdReq = 1'b0;
      bootSel = 2'h0;
      newCode = 11'h000;
      slewDiv = 16'h0000;
      step(6);
      nrst = 1'b1;
      boot(2'h0, boot_seq_pkg::BOOT_MV_00);
      boot(2'h1, boot_seq_pkg::BOOT_MV_01);
      boot(2'h3, boot_seq_pkg::BOOT_MV_11);
      boot(2'h2, boot_seq_pkg::BOOT_MV_10);
      slewDiv = 16'h0001;
      svi_and_return(11'h4B0, boot_seq_pkg::BOOT_MV_10);
      svi_and_return(11'h3E8, boot_seq_pkg::BOOT_MV_10);
      slewDiv = 16'h0000;
      follow_lines();
      slewDiv = 16'h0001;
      svi_and_return(11'h44C, boot_seq_pkg::BOOT_MV_11);
      groundB = 1'b1;
      step(2);
      check("combined", 16'(combined), 16'h0001);
      groundB = 1'b0;
      step(2);
      check("split", 16'(combined), 16'h0000);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
